//--- rtl/atassf_pkg.sv
package atassf_pkg;

  // task-file register indexes; byte address is four times the index
  localparam logic [3:0] IDX_FEAT = 4'h1; // write feature, read error
  localparam logic [3:0] IDX_SCNT = 4'h2;
  localparam logic [3:0] IDX_SNUM = 4'h3;
  localparam logic [3:0] IDX_CYLL = 4'h4;
  localparam logic [3:0] IDX_CYLH = 4'h5;
  localparam logic [3:0] IDX_DRVH = 4'h6;
  localparam logic [3:0] IDX_CMD = 4'h7; // write opcode, read status
  localparam logic [3:0] IDX_MODES = 4'h8; // mode readback
  localparam logic [3:0] IDX_OPTS = 4'h9; // option readback
  localparam logic [3:0] IDX_XCODE = 4'ha; // pending extended code

  // opcodes
  localparam logic [7:0] OP_SENSE = 8'h03;
  localparam logic [3:0] OP_SEEK_HI = 4'h7;
  localparam logic [7:0] OP_SETF = 8'hef;

  // set-features subcommands
  localparam logic [7:0] SF_8BIT_ON = 8'h01;
  localparam logic [7:0] SF_8BIT_OFF = 8'h81;
  localparam logic [7:0] SF_WC_ON = 8'h02;
  localparam logic [7:0] SF_WC_OFF = 8'h82;
  localparam logic [7:0] SF_XFER = 8'h03;
  localparam logic [7:0] SF_APM_ON = 8'h05;
  localparam logic [7:0] SF_APM_OFF = 8'h85;
  localparam logic [7:0] SF_XPWR_ON = 8'h09;
  localparam logic [7:0] SF_XPWR_OFF = 8'h89;
  localparam logic [7:0] SF_PL1_ON = 8'h0a;
  localparam logic [7:0] SF_PL1_OFF = 8'h8a;
  localparam logic [7:0] SF_ECC_VEND = 8'h44;
  localparam logic [7:0] SF_ECC_4 = 8'hbb;
  localparam logic [7:0] SF_RLA_OFF = 8'h55;
  localparam logic [7:0] SF_RLA_ON = 8'haa;
  localparam logic [7:0] SF_KEEP_ON = 8'h66;
  localparam logic [7:0] SF_KEEP_OFF = 8'hcc;
  localparam logic [7:0] SF_NOP_A = 8'h69;
  localparam logic [7:0] SF_NOP_B = 8'h96;
  localparam logic [7:0] SF_NOP_C = 8'h97;
  localparam logic [7:0] SF_CURCAP = 8'h9a;

  // transfer type field, upper five bits of the sector count
  localparam logic [4:0] XT_PIO_DEF = 5'h00;
  localparam logic [4:0] XT_PIO_FC = 5'h01;
  localparam logic [4:0] XT_MDMA = 5'h04;
  localparam logic [2:0] XM_DEF = 3'h0;
  localparam logic [2:0] XM_NO_IORDY = 3'h1;

  // extended error codes
  localparam logic [7:0] XC_NONE = 8'h00;
  localparam logic [7:0] XC_SELFTEST_OK = 8'h01;
  localparam logic [7:0] XC_MISC = 8'h09;
  localparam logic [7:0] XC_INV_CMD = 8'h20;
  localparam logic [7:0] XC_INV_ADDR = 8'h21;
  localparam logic [7:0] XC_ADDR_OVF = 8'h2f;
  localparam logic [7:0] XC_ABORTED = 8'h1f;

  // error and status register bits
  localparam logic [7:0] ER_ABRT = 8'h04;
  localparam logic [7:0] ER_IDNF = 8'h10;
  localparam int ST_BSY = 7;
  localparam int ST_RDY = 6;
  localparam int ST_DSC = 4;
  localparam int ST_ERR = 0;
  localparam int DH_LBA = 6;

  // power-on defaults
  localparam logic [2:0] PIO_RST = 3'h0;
  localparam logic [2:0] DMA_RST = 3'h0;
  localparam logic [7:0] CURCAP_RST = 8'h00;

  typedef enum {ATASSF_IDLE, ATASSF_FLUSH} atassf_state_t;

  // feature settings driven to the rest of the card
  typedef struct packed {
    logic eight_bit;
    logic wcache;
    logic iordy_off;
    logic [2:0] pio_mode;
    logic [2:0] dma_mode;
    logic apm;
    logic ext_power;
    logic pl1;
    logic rla;
    logic keep_settings;
    logic ecc_vendor;
    logic [7:0] cur_cap;
  } atassf_feat_t;

  localparam atassf_feat_t FEAT_RST = '{
    eight_bit: 1'b0, wcache: 1'b1, iordy_off: 1'b0, pio_mode: PIO_RST,
    dma_mode: DMA_RST, apm: 1'b0, ext_power: 1'b0, pl1: 1'b0, rla: 1'b1,
    keep_settings: 1'b0, ecc_vendor: 1'b0, cur_cap: CURCAP_RST};

endpackage : atassf_pkg

//--- rtl/atassf_core.sv
`timescale 1ns/1ps
module atassf_core #(
  parameter int CYLINDERS = 1978,
  parameter int HEADS = 16,
  parameter int SECTORS = 63,
  parameter int PIO_MAX = 6,
  parameter int DMA_MAX = 4,
  parameter bit DMA_CAPABLE = 1'b1
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic soft_rst_i,
  // wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [5:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // error reports of other command units
  input wire logic err_rpt_i,
  input wire logic [7:0] err_rpt_code_i,
  // cache flush handshake
  output logic flush_req_o,
  input wire logic flush_done_i,
  // settings and events
  output atassf_pkg::atassf_feat_t feat_o,
  output logic io16_ok_o,
  output logic cmd_done_o
);

  typedef struct packed {
    atassf_pkg::atassf_state_t fsm;
    logic ack;
    logic [31:0] dat;
    logic [7:0] feature;
    logic [7:0] scnt;
    logic [7:0] snum;
    logic [7:0] cyll;
    logic [7:0] cylh;
    logic [7:0] drvh;
    logic [7:0] error;
    logic [7:0] xcode;
    logic bsy;
    logic err;
    logic done;
    logic flush;
    logic io16;
    atassf_pkg::atassf_feat_t feat;
  } atassf_regs_t;

  atassf_regs_t s_reg;
  atassf_regs_t s_next;

  localparam logic [15:0] CYL_LIM = 16'(CYLINDERS);
  localparam logic [3:0] HEAD_LIM = 4'(HEADS - 1);
  localparam logic [27:0] LBA_LIM = 28'(CYLINDERS * HEADS * SECTORS);
  localparam logic [2:0] PIO_TOP = 3'(PIO_MAX);
  localparam logic [2:0] DMA_TOP = 3'(DMA_MAX);

  // address check for seek: 0 ok, else extended code
  function automatic logic [7:0] seek_check(input logic [7:0] dh, input logic [7:0] ch,
                                            input logic [7:0] cl, input logic [7:0] sn);
    logic [27:0] lba;
    lba = {dh[3:0], ch, cl, sn};
    seek_check = atassf_pkg::XC_NONE;
    if (dh[atassf_pkg::DH_LBA]) begin
      if (lba >= LBA_LIM) begin
        seek_check = atassf_pkg::XC_ADDR_OVF;
      end
    end else if ({ch, cl} >= CYL_LIM) begin
      seek_check = atassf_pkg::XC_ADDR_OVF;
    end else if (dh[3:0] > HEAD_LIM) begin
      seek_check = atassf_pkg::XC_INV_ADDR;
    end
  endfunction : seek_check

  // register readback by index
  function automatic logic [7:0] read_reg(input atassf_regs_t r, input logic [3:0] idx);
    read_reg = 8'h00;
    case (idx)
      atassf_pkg::IDX_FEAT: read_reg = r.error;
      atassf_pkg::IDX_SCNT: read_reg = r.scnt;
      atassf_pkg::IDX_SNUM: read_reg = r.snum;
      atassf_pkg::IDX_CYLL: read_reg = r.cyll;
      atassf_pkg::IDX_CYLH: read_reg = r.cylh;
      atassf_pkg::IDX_DRVH: read_reg = r.drvh;
      atassf_pkg::IDX_CMD: begin
        read_reg[atassf_pkg::ST_BSY] = r.bsy;
        read_reg[atassf_pkg::ST_RDY] = ~r.bsy;
        read_reg[atassf_pkg::ST_DSC] = ~r.bsy;
        read_reg[atassf_pkg::ST_ERR] = r.err;
      end
      atassf_pkg::IDX_MODES: read_reg = {r.feat.iordy_off, r.feat.dma_mode, 1'b0,
                                         r.feat.pio_mode};
      atassf_pkg::IDX_OPTS: read_reg = {r.feat.eight_bit, r.feat.wcache, r.feat.apm,
                                        r.feat.ext_power, r.feat.pl1, r.feat.rla,
                                        r.feat.keep_settings, r.feat.ecc_vendor};
      atassf_pkg::IDX_XCODE: read_reg = r.xcode;
      default: read_reg = 8'h00;
    endcase
  endfunction : read_reg

  logic wb_req;
  logic [3:0] idx;
  logic wr_lane0;

  assign wb_req = wb_cyc_i & wb_stb_i & ~s_reg.ack;
  assign idx = wb_adr_i[5:2];
  assign wr_lane0 = wb_req & wb_we_i & wb_sel_i[0];

  // next-state logic
  always_comb begin
    logic [7:0] op;
    logic [7:0] chk;
    logic [4:0] xtype;
    logic [2:0] xmode;
    op = wb_dat_i[7:0];
    chk = 8'h00;
    xtype = s_reg.scnt[7:3];
    xmode = s_reg.scnt[2:0];
    s_next = s_reg;
    s_next.done = 1'b0;
    s_next.ack = wb_req;
    s_next.dat = 32'h0000_0000;
    if (wb_req && !wb_we_i) begin
      s_next.dat = {24'h00_0000, read_reg(s_reg, idx)};
    end

    // register writes; task file held while busy
    if (wr_lane0 && !s_reg.bsy) begin
      case (idx)
        atassf_pkg::IDX_FEAT: s_next.feature = wb_dat_i[7:0];
        atassf_pkg::IDX_SCNT: s_next.scnt = wb_dat_i[7:0];
        atassf_pkg::IDX_SNUM: s_next.snum = wb_dat_i[7:0];
        atassf_pkg::IDX_CYLL: s_next.cyll = wb_dat_i[7:0];
        atassf_pkg::IDX_CYLH: s_next.cylh = wb_dat_i[7:0];
        atassf_pkg::IDX_DRVH: s_next.drvh = wb_dat_i[7:0];
        default: ;
      endcase
    end

    // outcome reports from other units become the pending code
    if (err_rpt_i) begin
      s_next.xcode = err_rpt_code_i;
    end

    case (s_reg.fsm)
      atassf_pkg::ATASSF_IDLE: begin
        // opcode write runs the command; parameters already loaded
        if (wr_lane0 && !s_reg.bsy && idx == atassf_pkg::IDX_CMD) begin
          s_next.err = 1'b0;
          s_next.error = 8'h00;
          s_next.xcode = atassf_pkg::XC_NONE;
          s_next.done = 1'b1;
          if (op == atassf_pkg::OP_SENSE) begin
            s_next.error = s_reg.xcode;
          end else if (op[7:4] == atassf_pkg::OP_SEEK_HI) begin
            chk = seek_check(s_reg.drvh, s_reg.cylh, s_reg.cyll, s_reg.snum);
            if (chk != atassf_pkg::XC_NONE) begin
              s_next.err = 1'b1;
              s_next.error = atassf_pkg::ER_IDNF;
              s_next.xcode = chk;
            end
          end else if (op == atassf_pkg::OP_SETF) begin
            case (s_reg.feature)
              atassf_pkg::SF_8BIT_ON: s_next.feat.eight_bit = 1'b1;
              atassf_pkg::SF_8BIT_OFF: s_next.feat.eight_bit = 1'b0;
              atassf_pkg::SF_WC_ON: s_next.feat.wcache = 1'b1;
              atassf_pkg::SF_WC_OFF: begin
                s_next.feat.wcache = 1'b0;
                s_next.flush = 1'b1;
                s_next.bsy = 1'b1;
                s_next.done = 1'b0;
                s_next.fsm = atassf_pkg::ATASSF_FLUSH;
              end
              atassf_pkg::SF_XFER: begin
                // type in upper five bits, mode in lower three
                if (xtype == atassf_pkg::XT_PIO_DEF &&
                    (xmode == atassf_pkg::XM_DEF || xmode == atassf_pkg::XM_NO_IORDY)) begin
                  s_next.feat.pio_mode = atassf_pkg::PIO_RST;
                  s_next.feat.iordy_off = (xmode == atassf_pkg::XM_NO_IORDY);
                end else if (xtype == atassf_pkg::XT_PIO_FC && xmode <= PIO_TOP) begin
                  s_next.feat.pio_mode = xmode;
                  s_next.feat.iordy_off = 1'b0;
                end else if (xtype == atassf_pkg::XT_MDMA && DMA_CAPABLE &&
                             xmode <= DMA_TOP) begin
                  s_next.feat.dma_mode = xmode;
                end else begin
                  s_next.err = 1'b1;
                end
              end
              atassf_pkg::SF_APM_ON: s_next.feat.apm = 1'b1;
              atassf_pkg::SF_APM_OFF: s_next.feat.apm = 1'b0;
              atassf_pkg::SF_PL1_ON: s_next.feat.pl1 = 1'b1;
              atassf_pkg::SF_PL1_OFF: s_next.feat.pl1 = 1'b0;
              atassf_pkg::SF_XPWR_ON: s_next.feat.ext_power = 1'b1;
              atassf_pkg::SF_XPWR_OFF: s_next.feat.ext_power = 1'b0;
              atassf_pkg::SF_RLA_OFF: s_next.feat.rla = 1'b0;
              atassf_pkg::SF_RLA_ON: s_next.feat.rla = 1'b1;
              atassf_pkg::SF_KEEP_ON: s_next.feat.keep_settings = 1'b1;
              atassf_pkg::SF_KEEP_OFF: s_next.feat.keep_settings = 1'b0;
              atassf_pkg::SF_ECC_VEND: s_next.feat.ecc_vendor = 1'b1;
              atassf_pkg::SF_ECC_4: s_next.feat.ecc_vendor = 1'b0;
              atassf_pkg::SF_CURCAP: s_next.feat.cur_cap = s_reg.scnt;
              atassf_pkg::SF_NOP_A, atassf_pkg::SF_NOP_B, atassf_pkg::SF_NOP_C: ;
              default: s_next.err = 1'b1;
            endcase
            // aborted subcommand: no setting changes
            if (s_next.err) begin
              s_next.feat = s_reg.feat;
              s_next.error = atassf_pkg::ER_ABRT;
              s_next.xcode = atassf_pkg::XC_ABORTED;
            end
          end else begin
            s_next.err = 1'b1;
            s_next.error = atassf_pkg::ER_ABRT;
            s_next.xcode = atassf_pkg::XC_INV_CMD;
          end
        end
      end
      atassf_pkg::ATASSF_FLUSH: begin
        // completion only after cached data is stored
        if (flush_done_i) begin
          s_next.flush = 1'b0;
          s_next.bsy = 1'b0;
          s_next.done = 1'b1;
          s_next.fsm = atassf_pkg::ATASSF_IDLE;
        end
      end
      default: s_next.fsm = atassf_pkg::ATASSF_IDLE;
    endcase

    // soft reset ends any command, restores defaults unless kept
    if (soft_rst_i) begin
      s_next.fsm = atassf_pkg::ATASSF_IDLE;
      s_next.bsy = 1'b0;
      s_next.err = 1'b0;
      s_next.flush = 1'b0;
      s_next.done = 1'b0;
      if (!s_reg.feat.keep_settings) begin
        s_next.feat = atassf_pkg::FEAT_RST;
      end
    end

    // 16-bit indication registered alongside the settings
    s_next.io16 = ~s_next.feat.eight_bit;
  end

  // state register
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s_reg <= '{fsm: atassf_pkg::ATASSF_IDLE, feat: atassf_pkg::FEAT_RST,
                 io16: ~atassf_pkg::FEAT_RST.eight_bit, default: '0};
    end else begin
      s_reg <= s_next;
    end
  end

  // outputs straight from state
  assign wb_ack_o = s_reg.ack;
  assign wb_dat_o = s_reg.dat;
  assign flush_req_o = s_reg.flush;
  assign feat_o = s_reg.feat;
  assign io16_ok_o = s_reg.io16;
  assign cmd_done_o = s_reg.done;

endmodule : atassf_core

//--- sim/atassf_flush_model.sv
`timescale 1ns/1ps
module atassf_flush_model (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // flush handshake
  input wire logic flush_req_i,
  input wire logic [7:0] dly_i,
  output logic flush_done_o
);
  logic [7:0] cnt_reg;
  // storage answers a flush dly_i+1 cycles after the request, one-cycle done pulse
  always_ff @(posedge clk_i) begin
    if (rst_i || !flush_req_i || flush_done_o) begin
      cnt_reg <= 8'h00;
      flush_done_o <= 1'b0;
    end else if (cnt_reg == dly_i) begin
      flush_done_o <= 1'b1;
    end else begin
      cnt_reg <= cnt_reg + 8'h01;
    end
  end
endmodule : atassf_flush_model

//--- sim/atassf_core_asserts.sv
`timescale 1ns/1ps
module atassf_core_asserts #(
  parameter int PIO_MAX = 6,
  parameter int DMA_MAX = 4
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic soft_rst_i,
  // bus handshake
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_ack_o,
  // flush and settings
  input wire logic flush_req_o,
  input wire logic flush_done_i,
  input wire atassf_pkg::atassf_feat_t feat_o,
  input wire logic io16_ok_o,
  input wire logic cmd_done_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  property p_io16;
    io16_ok_o == !feat_o.eight_bit;
  endproperty
  a_io16: assert property (p_io16) else $error("io16 wrong");
  property p_ack;
    wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o;
  endproperty
  a_ack: assert property (p_ack) else $error("no ack");
  property p_flush_end;
    flush_req_o && flush_done_i && !soft_rst_i |=> cmd_done_o && !flush_req_o;
  endproperty
  a_flush_end: assert property (p_flush_end) else $error("flush end wrong");
  property p_flush_hold;
    flush_req_o && !flush_done_i && !soft_rst_i |=> flush_req_o;
  endproperty
  a_flush_hold: assert property (p_flush_hold) else $error("flush dropped");
  property p_no_early_done;
    flush_req_o |-> !cmd_done_o;
  endproperty
  a_no_early_done: assert property (p_no_early_done) else $error("done in flush");
  property p_mode_range;
    feat_o.pio_mode <= PIO_MAX && feat_o.dma_mode <= DMA_MAX;
  endproperty
  a_mode_range: assert property (p_mode_range) else $error("mode out of range");
  property p_feat_src;
    !$stable(feat_o) && !$past(soft_rst_i) && !$past(rst_i) |-> cmd_done_o || flush_req_o;
  endproperty
  a_feat_src: assert property (p_feat_src) else $error("stray setting change");
  property p_keep;
    soft_rst_i && feat_o.keep_settings && !flush_req_o |=> $stable(feat_o);
  endproperty
  a_keep: assert property (p_keep) else $error("settings lost");
  property p_dflt;
    soft_rst_i && !feat_o.keep_settings |=> feat_o == atassf_pkg::FEAT_RST;
  endproperty
  a_dflt: assert property (p_dflt) else $error("defaults not restored");
  c_flush: cover property ($rose(flush_req_o));
  c_keep: cover property (soft_rst_i && feat_o.keep_settings);
  c_8bit: cover property ($rose(feat_o.eight_bit));
endmodule : atassf_core_asserts

bind atassf_core atassf_core_asserts #(.PIO_MAX(PIO_MAX), .DMA_MAX(DMA_MAX)) i_atassf_core_asserts (
  .clk_i(clk_i), .rst_i(rst_i), .soft_rst_i(soft_rst_i), .wb_cyc_i(wb_cyc_i),
  .wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o), .flush_req_o(flush_req_o),
  .flush_done_i(flush_done_i), .feat_o(feat_o), .io16_ok_o(io16_ok_o), .cmd_done_o(cmd_done_o));

//--- sim/testbench.sv
`timescale 1ns/1ps
module testbench;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic soft_rst_i = 1'b0;
  logic wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0;
  logic [5:0] wb_adr_i = 6'h00;
  logic [3:0] wb_sel_i = 4'h1;
  logic [31:0] wb_dat_i = 32'h0;
  logic [31:0] wb_dat_o;
  logic wb_ack_o, flush_req_o, flush_done_i, io16_ok_o, cmd_done_o;
  logic err_rpt_i = 1'b0;
  logic [7:0] err_rpt_code_i = 8'h00;
  logic [7:0] flush_dly = 8'h14;
  logic [7:0] v;
  atassf_pkg::atassf_feat_t feat_o;
  int err_count = 0, checks = 0, dones = 0, d0;
  // subcommand and option readback after it
  logic [15:0] sft [20] = '{16'h01c4, 16'h8144, 16'h0564, 16'h8544, 16'h0954, 16'h8944,
    16'h0a4c, 16'h8a44, 16'h5540, 16'haa44, 16'h4445, 16'hbb44, 16'h6646, 16'hcc44,
    16'h6944, 16'h9644, 16'h9744, 16'h0244, 16'h7744, 16'h0044};
  // sector count, mode readback, error
  logic [23:0] xft [7] = '{24'h0e0600, 24'h244600, 24'h0f4604, 24'h104604,
    24'h254604, 24'h01c000, 24'h004000};
  // drive/head, cyl high, cyl low, sector, opcode, error, pending code
  logic [55:0] skt [4] = '{56'haf07b90170_0000, 56'haf07ba017a_102f,
    56'he01e6c5f7f_0000, 56'he01e6c6073_102f};
  logic [7:0] xcs [8] = '{8'h11, 8'h18, 8'h10, 8'h3a, 8'h05, 8'h0c, 8'h35, 8'h22};

  initial forever #2 clk_i = ~clk_i;

  atassf_core i_atassf_core (.clk_i(clk_i), .rst_i(rst_i), .soft_rst_i(soft_rst_i),
    .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
    .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
    .err_rpt_i(err_rpt_i), .err_rpt_code_i(err_rpt_code_i), .flush_req_o(flush_req_o),
    .flush_done_i(flush_done_i), .feat_o(feat_o), .io16_ok_o(io16_ok_o),
    .cmd_done_o(cmd_done_o));
  atassf_flush_model i_atassf_flush_model (.clk_i(clk_i), .rst_i(rst_i),
    .flush_req_i(flush_req_o), .dly_i(flush_dly), .flush_done_o(flush_done_i));

  // count completion pulses
  always @(posedge clk_i) begin
    if (cmd_done_o === 1'b1) begin
      dones <= dones + 1;
    end
  end

  task automatic end_sim();
    $display("checks=%0d mismatches=%0d", checks, err_count);
    if (err_count == 0 && checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : end_sim

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      err_count++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  // one classic wishbone cycle, released only after ack is sampled
  task automatic bus(input logic we, input logic [3:0] idx, input logic [7:0] wd);
    int n;
    @(posedge clk_i);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= {idx, 2'h0};
    wb_dat_i <= {24'h0, wd};
    n = 0;
    do begin
      @(posedge clk_i);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 50);
    if (wb_ack_o !== 1'b1) begin
      err_count++;
      end_sim();
    end
    v = wb_dat_o[7:0];
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    wb_we_i <= 1'b0;
  endtask : bus

  task automatic rchk(input logic [3:0] idx, input logic [7:0] e);
    bus(1'b0, idx, 8'h00);
    chk(v, e);
  endtask : rchk

  task automatic wait_done(input int n0);
    int n;
    n = 0;
    while (dones == n0 && n < 200) begin
      @(posedge clk_i);
      n++;
    end
    if (dones == n0) begin
      err_count++;
      end_sim();
    end
  endtask : wait_done

  // parameters first, opcode last
  task automatic cmd(input logic [7:0] f, input logic [7:0] s, input logic [7:0] op);
    int n0;
    n0 = dones;
    bus(1'b1, 4'h1, f);
    bus(1'b1, 4'h2, s);
    bus(1'b1, 4'h7, op);
    wait_done(n0);
  endtask : cmd

  task automatic soft_pulse();
    @(posedge clk_i);
    soft_rst_i <= 1'b1;
    @(posedge clk_i);
    soft_rst_i <= 1'b0;
  endtask : soft_pulse

  initial begin
    repeat (6) @(posedge clk_i);
    rst_i <= 1'b0;
    rchk(4'h9, 8'h44);
    rchk(4'h8, 8'h00);
    rchk(4'ha, 8'h00);
    rchk(4'hf, 8'h00);
    $display("test reset done");
    foreach (sft[i]) begin
      cmd(sft[i][15:8], 8'h00, 8'hef);
      rchk(4'h9, sft[i][7:0]);
      rchk(4'h1, (i >= 18) ? 8'h04 : 8'h00);
      chk(io16_ok_o, !sft[i][7]);
    end
    cmd(8'h00, 8'h00, 8'h03);
    rchk(4'h1, 8'h1f);
    cmd(8'h9a, 8'h5a, 8'hef);
    chk(feat_o.cur_cap, 8'h5a);
    $display("test subcommands done");
    // 8-bit mode is off before any dma mode is chosen
    foreach (xft[i]) begin
      cmd(8'h03, xft[i][23:16], 8'hef);
      rchk(4'h8, xft[i][15:8]);
      rchk(4'h1, xft[i][7:0]);
    end
    $display("test transfer modes done");
    foreach (skt[i]) begin
      bus(1'b1, 4'h6, skt[i][55:48]);
      bus(1'b1, 4'h5, skt[i][47:40]);
      bus(1'b1, 4'h4, skt[i][39:32]);
      bus(1'b1, 4'h3, skt[i][31:24]);
      d0 = dones;
      bus(1'b1, 4'h7, skt[i][23:16]);
      wait_done(d0);
      rchk(4'h1, skt[i][15:8]);
      cmd(8'h00, 8'h00, 8'h03);
      rchk(4'h1, skt[i][7:0]);
    end
    cmd(8'h00, 8'h00, 8'h00);
    rchk(4'h1, 8'h04);
    cmd(8'h00, 8'h00, 8'h03);
    rchk(4'h1, 8'h20);
    cmd(8'h00, 8'h00, 8'h03);
    rchk(4'h1, 8'h00);
    $display("test seek and sense done");
    foreach (xcs[i]) begin
      @(posedge clk_i);
      err_rpt_i <= 1'b1;
      err_rpt_code_i <= xcs[i];
      @(posedge clk_i);
      err_rpt_i <= 1'b0;
      rchk(4'ha, xcs[i]);
      cmd(8'h00, 8'h00, 8'h03);
      rchk(4'h1, xcs[i]);
    end
    $display("test reported codes done");
    bus(1'b1, 4'h2, 8'h11);
    bus(1'b1, 4'h1, 8'h82);
    d0 = dones;
    bus(1'b1, 4'h7, 8'hef);
    bus(1'b0, 4'h7, 8'h00);
    chk(v[7], 1'b1);
    chk(flush_req_o, 1'b1);
    bus(1'b1, 4'h2, 8'h77);
    wait_done(d0);
    rchk(4'h2, 8'h11);
    rchk(4'h9, 8'h04);
    flush_dly <= 8'h00;
    cmd(8'h82, 8'h00, 8'hef);
    rchk(4'h9, 8'h04);
    cmd(8'h02, 8'h00, 8'hef);
    $display("test cache flush done");
    cmd(8'h55, 8'h00, 8'hef);
    soft_pulse();
    rchk(4'h9, 8'h44);
    cmd(8'h66, 8'h00, 8'hef);
    cmd(8'h55, 8'h00, 8'hef);
    soft_pulse();
    rchk(4'h9, 8'h42);
    cmd(8'hcc, 8'h00, 8'hef);
    soft_pulse();
    rchk(4'h9, 8'h44);
    $display("test soft reset done");
    end_sim();
  end
endmodule : testbench
